//--- rtl/timer16_pkg.sv
package timer16_pkg;
  // Register byte offsets, one aligned word each
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CNT_L = 6'h04;
  localparam logic [5:0] OFS_CNT_H = 6'h08;
  localparam logic [5:0] OFS_CMPA_L = 6'h0C;
  localparam logic [5:0] OFS_CMPA_H = 6'h10;
  localparam logic [5:0] OFS_CMPB_L = 6'h14;
  localparam logic [5:0] OFS_CMPB_H = 6'h18;
  localparam logic [5:0] OFS_CAP_L = 6'h1C;
  localparam logic [5:0] OFS_CAP_H = 6'h20;
  localparam logic [5:0] OFS_STAT = 6'h24;
  localparam logic [5:0] OFS_MASK = 6'h28;
  // Control word fields
  localparam int unsigned CTL_RES_LSB = 0;
  localparam int unsigned CTL_MODEA_LSB = 2;
  localparam int unsigned CTL_MODEB_LSB = 4;
  localparam int unsigned CTL_CS_LSB = 6;
  localparam int unsigned CTL_EDGE_BIT = 9;
  localparam int unsigned CTL_GIE_BIT = 10;
  localparam int unsigned CTRL_W = 11;
  localparam logic [10:0] CTRL_RST = 11'h000;
  // Status and mask bits
  localparam int unsigned ST_OVF = 0;
  localparam int unsigned ST_CMPA = 1;
  localparam int unsigned ST_CMPB = 2;
  localparam int unsigned ST_CAP = 3;
  localparam int unsigned ST_W = 4;
  // Resolution codes; zero keeps the plain up counter
  localparam logic [1:0] RES_OFF = 2'h0;
  localparam logic [1:0] RES_8 = 2'h1;
  localparam logic [1:0] RES_9 = 2'h2;
  localparam logic [1:0] RES_10 = 2'h3;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam int unsigned CMP_PWM_W = 10;
  // Output modes
  localparam logic [1:0] MODE_NONINV = 2'h2;
  localparam logic [1:0] MODE_INV = 2'h3;
  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Prescaler tap widths: divide by two to the power of these
  localparam int unsigned PRE_W = 10;
  localparam int unsigned TAP8 = 3;
  localparam int unsigned TAP64 = 6;
  localparam int unsigned TAP256 = 8;
endpackage : timer16_pkg

//--- rtl/timer16_capture_pwm.sv
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
// Behaviour
// - Selected capture edge copies counter into capture register and sets capture flag.
// - Capture register read-only; low read stages high byte, high read returns stage.
// - One staging byte serves counter, both compares and capture register.
// - PWM counter runs zero up to top, back down to zero, repeating.
// - Resolution picks top 0x00FF, 0x01FF or 0x03FF, shared by both channels.
// - PWM period is twice top in timer ticks: divide by 510, 1022, 2046.
// - Match of counter with low ten compare bits sets or clears channel pin.
// - Mode 10 clears rising, sets falling; 11 inverse; 00 and 01 disconnect.
// - PWM compare writes go to holding value, loaded when counter reaches top.
// - Compare reads return the holding value, the latest write.
// - Compare zero drives low in mode 10, high in 11; top the opposite.
// - PWM overflow flag sets when counter advances away from zero.
// - Interrupt raised from set flag with its enable and global enable on.
// - Clock select: stop, divide 1/8/64/256/1024, external falling or rising edge.
module timer16_capture_pwm #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic capture_input_pin_i,
  input wire logic ext_count_pin_i,
  output logic pwm_output_a_o,
  output logic pwm_output_a_oe_n_o,
  output logic pwm_output_b_o,
  output logic pwm_output_b_oe_n_o,
  output logic irq_o
);
  // Byte staging and 16-bit layout assume exactly two bytes
  if (CNT_W != 16) begin : g_bad_width
    $error("CNT_W must be 16");
  end

  logic wait_q, req, acc, wr_acc, rd_pre;
  logic [31:0] rd_mux;
  logic [timer16_pkg::CTRL_W-1:0] ctrl_q;
  logic [timer16_pkg::ST_W-1:0] status_q, mask_q, st_set, st_clr;
  logic [7:0] stage_q;
  logic [15:0] cnt_q, cnt_d, cap_q, top_w;
  logic dir_q, dir_d, cnt_wr, tick, pwm_on, step_up, cap_evt;
  logic [timer16_pkg::PRE_W-1:0] presc_q;
  logic cap_s1_q, cap_s2_q, cap_s3_q, ext_s1_q, ext_s2_q, ext_s3_q;
  logic [15:0] hold_q [2], act_q [2];
  logic [1:0] match, pin_q, oe_n_q, res_w, mode_w [2];
  logic [2:0] cs_w;

  // Accepted write to a byte register at a given offset
  function automatic logic wr_hit(input logic [5:0] ofs);
    return wr_acc && (avs_address_i == ofs) && avs_byteenable_i[0];
  endfunction : wr_hit

  // Top value for a resolution code
  function automatic logic [15:0] top_of(input logic [1:0] res);
    unique case (res)
      timer16_pkg::RES_8: return timer16_pkg::TOP_8;
      timer16_pkg::RES_9: return timer16_pkg::TOP_9;
      timer16_pkg::RES_10: return timer16_pkg::TOP_10;
      default: return timer16_pkg::CNT_MAX;
    endcase
  endfunction : top_of

  // Pin level after a match; end values override the direction
  function automatic logic out_level(input logic inv, input logic up,
                                     input logic zero, input logic at_top);
    if (zero) return inv;
    if (at_top) return ~inv;
    return inv ? up : ~up;
  endfunction : out_level

  assign res_w = ctrl_q[timer16_pkg::CTL_RES_LSB +: 2];
  assign mode_w[0] = ctrl_q[timer16_pkg::CTL_MODEA_LSB +: 2];
  assign mode_w[1] = ctrl_q[timer16_pkg::CTL_MODEB_LSB +: 2];
  assign cs_w = ctrl_q[timer16_pkg::CTL_CS_LSB +: 3];
  assign pwm_on = (res_w != timer16_pkg::RES_OFF);
  assign top_w = top_of(res_w);

  // Bus handshake: one wait cycle, then the request is taken
  assign req = avs_read_i | avs_write_i;
  assign acc = req & ~wait_q;
  assign wr_acc = acc & avs_write_i;
  assign rd_pre = avs_read_i & wait_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) wait_q <= 1'b1;
    else wait_q <= ~(req & wait_q);
  end

  // Read data, captured the edge before the read is taken
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_i)
      timer16_pkg::OFS_CTRL: rd_mux[timer16_pkg::CTRL_W-1:0] = ctrl_q;
      timer16_pkg::OFS_CNT_L: rd_mux[7:0] = cnt_q[7:0];
      timer16_pkg::OFS_CNT_H: rd_mux[7:0] = stage_q;
      timer16_pkg::OFS_CMPA_L: rd_mux[7:0] = hold_q[0][7:0];
      timer16_pkg::OFS_CMPA_H: rd_mux[7:0] = hold_q[0][15:8];
      timer16_pkg::OFS_CMPB_L: rd_mux[7:0] = hold_q[1][7:0];
      timer16_pkg::OFS_CMPB_H: rd_mux[7:0] = hold_q[1][15:8];
      timer16_pkg::OFS_CAP_L: rd_mux[7:0] = cap_q[7:0];
      timer16_pkg::OFS_CAP_H: rd_mux[7:0] = stage_q;
      timer16_pkg::OFS_STAT: rd_mux[timer16_pkg::ST_W-1:0] = status_q;
      timer16_pkg::OFS_MASK: rd_mux[timer16_pkg::ST_W-1:0] = mask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) avs_readdata_o <= 32'h0000_0000;
    else if (rd_pre) avs_readdata_o <= rd_mux;
  end
  assign avs_waitrequest_o = wait_q;

  // Control and mask registers; lane 1 holds the upper control bits
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= timer16_pkg::CTRL_RST;
      mask_q <= '0;
    end else begin
      if (wr_hit(timer16_pkg::OFS_CTRL)) ctrl_q[7:0] <= avs_writedata_i[7:0];
      if (wr_acc && avs_address_i == timer16_pkg::OFS_CTRL && avs_byteenable_i[1]) begin
        ctrl_q[timer16_pkg::CTRL_W-1:8] <= avs_writedata_i[timer16_pkg::CTRL_W-1:8];
      end
      if (wr_hit(timer16_pkg::OFS_MASK)) mask_q <= avs_writedata_i[timer16_pkg::ST_W-1:0];
    end
  end

  // Shared staging byte; a race between two users is software's to avoid
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) stage_q <= 8'h00;
    else if (wr_hit(timer16_pkg::OFS_CNT_H) || wr_hit(timer16_pkg::OFS_CMPA_H) ||
             wr_hit(timer16_pkg::OFS_CMPB_H)) stage_q <= avs_writedata_i[7:0];
    else if (acc && avs_read_i && avs_address_i == timer16_pkg::OFS_CNT_L) begin
      stage_q <= cnt_q[15:8];
    end else if (acc && avs_read_i && avs_address_i == timer16_pkg::OFS_CAP_L) begin
      stage_q <= cap_q[15:8];
    end
  end

  // Pin synchronisers; the second and third stages feed edge logic
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      {cap_s1_q, cap_s2_q, cap_s3_q, ext_s1_q, ext_s2_q, ext_s3_q} <= 6'h00;
    end else begin
      {cap_s1_q, cap_s2_q, cap_s3_q} <= {capture_input_pin_i, cap_s1_q, cap_s2_q};
      {ext_s1_q, ext_s2_q, ext_s3_q} <= {ext_count_pin_i, ext_s1_q, ext_s2_q};
    end
  end
  assign cap_evt = ctrl_q[timer16_pkg::CTL_EDGE_BIT] ? (cap_s2_q & ~cap_s3_q)
                                                     : (~cap_s2_q & cap_s3_q);

  // Prescaler runs free so a divisor change takes effect at once
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) presc_q <= '0;
    else presc_q <= presc_q + 1'b1;
  end
  always_comb begin
    unique case (cs_w)
      timer16_pkg::CS_STOP: tick = 1'b0;
      timer16_pkg::CS_DIV1: tick = 1'b1;
      timer16_pkg::CS_DIV8: tick = &presc_q[timer16_pkg::TAP8-1:0];
      timer16_pkg::CS_DIV64: tick = &presc_q[timer16_pkg::TAP64-1:0];
      timer16_pkg::CS_DIV256: tick = &presc_q[timer16_pkg::TAP256-1:0];
      timer16_pkg::CS_DIV1024: tick = &presc_q;
      timer16_pkg::CS_EXT_FALL: tick = ~ext_s2_q & ext_s3_q;
      timer16_pkg::CS_EXT_RISE: tick = ext_s2_q & ~ext_s3_q;
    endcase
  end

  // Next count: plain up counter, or up/down between zero and top
  always_comb cnt_wr = wr_hit(timer16_pkg::OFS_CNT_L);
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (cnt_wr) begin
      cnt_d = {stage_q, avs_writedata_i[7:0]};
    end else if (tick) begin
      if (!pwm_on) dir_d = 1'b0;
      else if (!dir_q && cnt_q >= top_w) dir_d = 1'b1;
      else if (dir_q && cnt_q == timer16_pkg::CNT_ZERO) dir_d = 1'b0;
      cnt_d = dir_d ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
    end
  end
  assign step_up = ~dir_d;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) {cnt_q, dir_q} <= 17'h0_0000;
    else {cnt_q, dir_q} <= {cnt_d, dir_d};
  end

  // Capture register, overwritten by every capture
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) cap_q <= 16'h0000;
    else if (cap_evt) cap_q <= cnt_q;
  end

  // Compare channels
  for (genvar i = 0; i < 2; i++) begin : g_chan
    localparam logic [5:0] OFS_L = (i == 0) ? timer16_pkg::OFS_CMPA_L : timer16_pkg::OFS_CMPB_L;
    // Ten-bit match in PWM; a counter write never matches
    assign match[i] = tick && !cnt_wr &&
        (pwm_on ? (cnt_d[timer16_pkg::CMP_PWM_W-1:0] == act_q[i][timer16_pkg::CMP_PWM_W-1:0])
                : (cnt_d == act_q[i]));
    // Low byte write commits the staged high byte
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) hold_q[i] <= 16'h0000;
      else if (wr_hit(OFS_L)) hold_q[i] <= {stage_q, avs_writedata_i[7:0]};
    end
    // Latch at top keeps mid-period writes from making odd pulses
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) act_q[i] <= 16'h0000;
      else if (!pwm_on) act_q[i] <= hold_q[i];
      else if (tick && !cnt_wr && cnt_d == top_w) act_q[i] <= hold_q[i];
    end
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        pin_q[i] <= 1'b0;
        oe_n_q[i] <= 1'b1;
      end else begin
        oe_n_q[i] <= ~(pwm_on & mode_w[i][1]);
        if (match[i] && pwm_on && mode_w[i][1]) begin
          pin_q[i] <= out_level(mode_w[i][0], step_up,
              act_q[i][timer16_pkg::CMP_PWM_W-1:0] == '0,
              act_q[i][timer16_pkg::CMP_PWM_W-1:0] == top_w[timer16_pkg::CMP_PWM_W-1:0]);
        end
      end
    end
  end
  assign pwm_output_a_o = pin_q[0];
  assign pwm_output_b_o = pin_q[1];
  assign pwm_output_a_oe_n_o = oe_n_q[0];
  assign pwm_output_b_oe_n_o = oe_n_q[1];

  // Sticky status, write one to clear; a same-cycle set wins
  always_comb begin
    st_set = '0;
    st_set[timer16_pkg::ST_OVF] = tick && !cnt_wr &&
        (pwm_on ? (cnt_q == timer16_pkg::CNT_ZERO) : (cnt_q == timer16_pkg::CNT_MAX));
    st_set[timer16_pkg::ST_CMPA] = match[0];
    st_set[timer16_pkg::ST_CMPB] = match[1];
    st_set[timer16_pkg::ST_CAP] = cap_evt;
    st_clr = wr_hit(timer16_pkg::OFS_STAT) ? avs_writedata_i[timer16_pkg::ST_W-1:0] : '0;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) status_q <= '0;
    else status_q <= (status_q & ~st_clr) | st_set;
  end

  // Level interrupt behind per-bit mask and global enable
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) irq_o <= 1'b0;
    else irq_o <= (|(status_q & mask_q)) & ctrl_q[timer16_pkg::CTL_GIE_BIT];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_pwm_tick;
    pwm_on && tick && !cnt_wr;
  endsequence
  sequence s_cap_lo_taken;
    acc && avs_read_i && avs_address_i == timer16_pkg::OFS_CAP_L;
  endsequence
  sequence s_cap_hi_loaded;
    rd_pre && avs_address_i == timer16_pkg::OFS_CAP_H;
  endsequence

  property p_capture;
    cap_evt |=> cap_q == $past(cnt_q) && status_q[timer16_pkg::ST_CAP];
  endproperty
  a_capture: assert property (p_capture) else $error("capture value or flag wrong");
  property p_cap_pair;
    s_cap_lo_taken ##2 s_cap_hi_loaded |=> avs_readdata_o[7:0] == $past(cap_q[15:8], 3);
  endproperty
  a_cap_pair: assert property (p_cap_pair) else $error("capture high byte not staged");
  property p_stage_cnt;
    acc && avs_read_i && avs_address_i == timer16_pkg::OFS_CNT_L |=> stage_q == $past(cnt_q[15:8]);
  endproperty
  a_stage_cnt: assert property (p_stage_cnt) else $error("counter high not staged");
  property p_step_up;
    s_pwm_tick and (!dir_q && cnt_q < top_w) |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_step_up: assert property (p_step_up) else $error("pwm up step wrong");
  property p_turn;
    s_pwm_tick and (!dir_q && cnt_q == top_w) |=> dir_q && cnt_q == $past(top_w) - 16'h0001;
  endproperty
  a_turn: assert property (p_turn) else $error("no turn at top");
  property p_top_sel;
    res_w == timer16_pkg::RES_9 |-> top_w == timer16_pkg::TOP_9;
  endproperty
  a_top_sel: assert property (p_top_sel) else $error("top value wrong");
  property p_latch;
    s_pwm_tick and (cnt_d == top_w) |=> act_q[0] == $past(hold_q[0]);
  endproperty
  a_latch: assert property (p_latch) else $error("compare not latched at top");
  property p_readback;
    rd_pre && avs_address_i == timer16_pkg::OFS_CMPA_L |=> avs_readdata_o[7:0] == $past(hold_q[0][7:0]);
  endproperty
  a_readback: assert property (p_readback) else $error("compare readback wrong");
  property p_zero_low;
    match[0] && pwm_on && mode_w[0] == timer16_pkg::MODE_NONINV && act_q[0][9:0] == 10'h000
      |=> !pwm_output_a_o;
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero compare not low");
  property p_noninv_up;
    match[1] && pwm_on && mode_w[1] == timer16_pkg::MODE_NONINV && step_up
      && act_q[1][9:0] != top_w[9:0] |=> !pwm_output_b_o;
  endproperty
  a_noninv_up: assert property (p_noninv_up) else $error("up match did not clear");
  property p_disconnect;
    !mode_w[0][1] |=> pwm_output_a_oe_n_o;
  endproperty
  a_disconnect: assert property (p_disconnect) else $error("pin driven in off mode");
  property p_ovf;
    s_pwm_tick and (cnt_q == 16'h0000) |=> status_q[timer16_pkg::ST_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missed");
  property p_irq;
    (|(status_q & mask_q)) && ctrl_q[timer16_pkg::CTL_GIE_BIT] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  property p_stop;
    cs_w == timer16_pkg::CS_STOP && !cnt_wr |=> $stable(cnt_q);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");
  property p_one_evt;
    cap_evt |=> !cap_evt;
  endproperty
  a_one_evt: assert property (p_one_evt) else $error("double capture event");
endmodule : timer16_capture_pwm

//--- testbench/pwm_load_model.sv
`timescale 1ns/1ps
// Capture pulse source, external count source and PWM load timing the pin
module pwm_load_model (
  input wire logic clk_i,
  input wire logic pwm_a_i,
  output logic cap_pin_o,
  output logic ext_pin_o,
  output logic [15:0] period_o
);
  logic [15:0] run_q;
  logic last_q;

  initial begin
    cap_pin_o = 1'b0;
    ext_pin_o = 1'b0;
    period_o = 16'h0000;
    run_q = 16'h0000;
    last_q = 1'b0;
  end

  // Period taken rise to rise with no averaging, so one odd cycle shows
  always @(posedge clk_i) begin
    last_q <= pwm_a_i;
    if (pwm_a_i && !last_q) begin
      period_o <= run_q + 16'h0001;
      run_q <= 16'h0000;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end

  // Level held long enough for the two-flop sync and edge detect
  task automatic cap_set(input logic lvl);
    @(posedge clk_i);
    cap_pin_o <= lvl;
    repeat (8) @(posedge clk_i);
  endtask : cap_set

  // Slow pulses; the pin is async, so each level lasts several clocks
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_pin_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_pin_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : ext_pulses
endmodule : pwm_load_model

//--- testbench/timer16_capture_pwm_tb.sv
`timescale 1ns/1ps
// Register table, capture, interrupt, clock select and PWM checks
module timer16_capture_pwm_tb;
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] address = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_o, cap_pin, ext_pin, irq;
  logic pwm_a, pwm_a_oe_n, pwm_b, pwm_b_oe_n;
  logic lo_a, lo_b;
  logic [15:0] top;
  logic [15:0] period;
  logic [3:0] be = 4'hF;
  logic [31:0] d;
  row_t rows [0:19];
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;

  timer16_capture_pwm i_timer16_capture_pwm (
    .clk_i(clk), .rst_n_i(rst_n), .avs_address_i(address), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
    .capture_input_pin_i(cap_pin), .ext_count_pin_i(ext_pin),
    .pwm_output_a_o(pwm_a), .pwm_output_a_oe_n_o(pwm_a_oe_n),
    .pwm_output_b_o(pwm_b), .pwm_output_b_oe_n_o(pwm_b_oe_n), .irq_o(irq)
  );

  pwm_load_model i_pwm_load_model (
    .clk_i(clk), .pwm_a_i(pwm_a), .cap_pin_o(cap_pin), .ext_pin_o(ext_pin),
    .period_o(period)
  );

  // Free-running 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end

  // Ceiling well above the roughly 21k cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    wdata <= wd;
    wr <= we;
    rd <= !we;
    @(posedge clk);
    while (wait_o !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) begin
      err_total++;
      $display("BAD t=%0t bus stuck", $time);
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wrr(input logic [5:0] a, input logic [31:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, q);
  endtask : wrr

  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rdchk

  // Main sequence; the staging byte is shared, so row order matters
  initial begin
    rows = '{
      '{1'b0, timer16_pkg::OFS_CTRL, 32'h0, 32'h0},
      '{1'b0, timer16_pkg::OFS_STAT, 32'h0, 32'h0},
      '{1'b0, timer16_pkg::OFS_CAP_L, 32'h0, 32'h0},
      '{1'b1, timer16_pkg::OFS_MASK, 32'hF, 32'h0},
      '{1'b0, timer16_pkg::OFS_MASK, 32'h0, 32'hF},
      '{1'b1, 6'h2C, 32'h55, 32'h0},
      '{1'b0, 6'h2C, 32'h0, 32'h0},
      '{1'b1, timer16_pkg::OFS_CAP_L, 32'hAA, 32'h0},
      '{1'b0, timer16_pkg::OFS_CAP_L, 32'h0, 32'h0},
      '{1'b1, timer16_pkg::OFS_CNT_H, 32'h12, 32'h0},
      '{1'b1, timer16_pkg::OFS_CNT_L, 32'h34, 32'h0},
      '{1'b0, timer16_pkg::OFS_CNT_L, 32'h0, 32'h34},
      '{1'b0, timer16_pkg::OFS_CNT_H, 32'h0, 32'h12},
      '{1'b1, timer16_pkg::OFS_CMPA_H, 32'h2, 32'h0},
      '{1'b1, timer16_pkg::OFS_CMPA_L, 32'h7F, 32'h0},
      '{1'b0, timer16_pkg::OFS_CMPA_L, 32'h0, 32'h7F},
      '{1'b0, timer16_pkg::OFS_CMPA_H, 32'h0, 32'h2},
      '{1'b1, timer16_pkg::OFS_CMPB_H, 32'h9A, 32'h0},
      '{1'b0, timer16_pkg::OFS_CNT_H, 32'h0, 32'h9A},
      '{1'b1, timer16_pkg::OFS_MASK, 32'h0, 32'h0}
    };
    repeat (6) @(posedge clk);
    chk({pwm_a, pwm_a_oe_n, pwm_b, pwm_b_oe_n, irq, wait_o}, 6'b010101);
    rst_n <= 1'b1;
    foreach (rows[k]) begin
      bus(rows[k].we, rows[k].addr, rows[k].data, d);
      if (!rows[k].we) begin
        chk(d, rows[k].exp);
      end
    end
    // Lane 0 off: the byte write must be dropped
    be <= 4'hE;
    wrr(timer16_pkg::OFS_MASK, 32'hF);
    be <= 4'hF;
    rdchk(timer16_pkg::OFS_MASK, 32'h0);
    // Rising edge selected, counter parked at 0x1234
    wrr(timer16_pkg::OFS_CTRL, 32'h200);
    i_pwm_load_model.cap_set(1'b1);
    rdchk(timer16_pkg::OFS_STAT, 32'h8);
    rdchk(timer16_pkg::OFS_CAP_L, 32'h34);
    rdchk(timer16_pkg::OFS_CAP_H, 32'h12);
    wrr(timer16_pkg::OFS_STAT, 32'h8);
    i_pwm_load_model.cap_set(1'b0);
    rdchk(timer16_pkg::OFS_STAT, 32'h0);
    // Two captures left unread: the later value wins, flag stays
    wrr(timer16_pkg::OFS_CNT_H, 32'h56);
    wrr(timer16_pkg::OFS_CNT_L, 32'h78);
    i_pwm_load_model.cap_set(1'b1);
    i_pwm_load_model.cap_set(1'b0);
    wrr(timer16_pkg::OFS_CNT_H, 32'h9A);
    wrr(timer16_pkg::OFS_CNT_L, 32'hBC);
    i_pwm_load_model.cap_set(1'b1);
    rdchk(timer16_pkg::OFS_CAP_L, 32'hBC);
    rdchk(timer16_pkg::OFS_CAP_H, 32'h9A);
    rdchk(timer16_pkg::OFS_STAT, 32'h8);
    // Interrupt needs flag, mask bit and global enable together
    wrr(timer16_pkg::OFS_MASK, 32'h8);
    wrr(timer16_pkg::OFS_CTRL, 32'h600);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wrr(timer16_pkg::OFS_CTRL, 32'h200);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    wrr(timer16_pkg::OFS_CTRL, 32'h600);
    wrr(timer16_pkg::OFS_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    wrr(timer16_pkg::OFS_MASK, 32'h8);
    wrr(timer16_pkg::OFS_STAT, 32'h8);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    // External count source, falling then rising edge
    for (int cs = 6; cs < 8; cs++) begin
      wrr(timer16_pkg::OFS_CTRL, 32'(cs) << 6);
      wrr(timer16_pkg::OFS_CNT_H, 32'h0);
      wrr(timer16_pkg::OFS_CNT_L, 32'h0);
      i_pwm_load_model.ext_pulses(5);
      rdchk(timer16_pkg::OFS_CNT_L, 32'h5);
    end
    // Each resolution: A non-inverted, B inverted but non-inverted at 9-bit
    for (int r = 1; r < 4; r++) begin
      top = 16'((256 << (r - 1)) - 1);
      wrr(timer16_pkg::OFS_CMPA_H, 32'h0);
      wrr(timer16_pkg::OFS_CMPA_L, 32'h40);
      wrr(timer16_pkg::OFS_CMPB_L, 32'h40);
      wrr(timer16_pkg::OFS_CTRL, ((r == 2) ? 32'h68 : 32'h78) | 32'(r));
      wrr(timer16_pkg::OFS_STAT, 32'hF);
      repeat (6 * top) @(posedge clk);
      chk(period, {top, 1'b0});
      chk({pwm_b, pwm_a_oe_n, pwm_b_oe_n}, {pwm_a ^ (r != 2), 2'b00});
      bus(1'b0, timer16_pkg::OFS_STAT, 32'h0, d);
      chk(d & 32'h1, 32'h1);
    end
    wrr(timer16_pkg::OFS_CMPA_L, 32'h99);
    rdchk(timer16_pkg::OFS_CMPA_L, 32'h99);
    // A at top and B at zero both hold the pin high all period
    wrr(timer16_pkg::OFS_CMPA_H, 32'h3);
    wrr(timer16_pkg::OFS_CMPA_L, 32'hFF);
    wrr(timer16_pkg::OFS_CMPB_H, 32'h0);
    wrr(timer16_pkg::OFS_CMPB_L, 32'h0);
    repeat (4200) @(posedge clk);  // Latch waits for top, then a period to show
    lo_a = 1'b0;
    lo_b = 1'b0;
    repeat (2100) begin
      @(posedge clk);
      lo_a = lo_a | !pwm_a;
      lo_b = lo_b | !pwm_b;
    end
    chk({lo_a, lo_b}, 2'b00);
    // A at zero and B at top, 8-bit: both pins held low all period
    wrr(timer16_pkg::OFS_CMPA_H, 32'h0);
    wrr(timer16_pkg::OFS_CMPA_L, 32'h0);
    wrr(timer16_pkg::OFS_CMPB_L, 32'hFF);
    wrr(timer16_pkg::OFS_CTRL, 32'h79);
    repeat (2600) @(posedge clk);
    lo_a = 1'b0;
    lo_b = 1'b0;
    repeat (1100) begin
      @(posedge clk);
      lo_a = lo_a | pwm_a;
      lo_b = lo_b | pwm_b;
    end
    chk({lo_a, lo_b}, 2'b00);
    // Reset in mid-run returns pins and bus to rest
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({pwm_a, pwm_a_oe_n, pwm_b, pwm_b_oe_n, irq, wait_o}, 6'b010101);
    rst_n <= 1'b1;
    rdchk(timer16_pkg::OFS_CTRL, 32'h0);
    give_verdict();
  end
endmodule : timer16_capture_pwm_tb
